// ---- logic/ofv_limit_vf.sv ----
/*
 ofv_limit_vf: output frequency limiting, resonance skipping, ramping and
 the voltage-versus-frequency characteristic of a motor drive.
 Assumes all command inputs come from logic on CLK and that software
 reaches the settings over the plain register port.
*/
// The plain strobed port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module ofv_limit_vf
   import ofv_pkg::*;
#(
   parameter int unsigned TICK_CYC = RAMP_TICK_CYC
)(
   // clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // register port
   input wire logic [ADDR_W-1:0] REG_ADDR,
   input wire ofv_word_t REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output ofv_word_t REG_RDATA,
   // drive commands
   input wire ofv_word_t FREQ_CMD,
   input wire logic FREQ_CMD_VALID,
   input wire logic START,
   input wire logic JOG,
   input wire logic ALT_SET_SELECT,
   input wire logic REVERSE,
   input wire logic STALL_ACTIVE,
   input wire ofv_word_t STALL_FREQ,
   input wire ofv_word_t SUPPLY_VOLT,
   input wire ofv_word_t TORQUE_BOOST,
   // drive outputs
   output ofv_word_t FREQ_OUT,
   output ofv_word_t VOLT_OUT,
   output ofv_word_t BOOST_OUT,
   output ofv_word_t KNEE_FREQ_OUT,
   output logic S_CURVE_ACTIVE
);

   localparam logic [31:0] TICK_LAST = 32'(TICK_CYC - 1);

   ofv_cfg_t cfg_reg, cfg_next;
   ofv_word_t rdata_reg, rdata_next;
   logic [31:0] tick_cnt_reg, tick_cnt_next;
   logic tick;
   ofv_word_t freq_reg, freq_next;
   ofv_word_t volt_reg, volt_next;
   ofv_word_t boost_reg, boost_next;
   ofv_word_t knee_reg, knee_next;
   logic [3:0] flag_reg, flag_next;
   logic open_grp;
   logic run;
   ofv_word_t lower_f, raw_f, clamped_f, skipped_f, target_f;
   ofv_word_t knee_f, base_v, supply95, step;
   logic skip_hit, alt_on;

   // settings writes; out-of-range values are dropped, old value stays
   assign open_grp = (cfg_reg.vis_grp == 16'h0000);
   always_comb begin
      cfg_next = cfg_reg;
      if (REG_WR) begin
         for (int i = 0; i < NUM_BANDS; i++) begin
            if (open_grp &&
                (REG_WDATA <= FREQ_400 || REG_WDATA == CODE_OFF)) begin
               if (REG_ADDR == OFS_SKIP_BASE + 8'(i) * OFS_SKIP_STRIDE) begin
                  cfg_next.skip_a[i] = REG_WDATA;
               end
               if (REG_ADDR == OFS_SKIP_BASE + 8'(i) * OFS_SKIP_STRIDE
                   + OFS_SKIP_B) begin
                  cfg_next.skip_b[i] = REG_WDATA;
               end
            end
         end
         case (REG_ADDR)
            OFS_MAX_LIMIT: begin
               if (REG_WDATA <= FREQ_120) begin
                  cfg_next.max_lim = REG_WDATA;
                  cfg_next.hs_lim = REG_WDATA;
               end
            end
            OFS_HS_LIMIT: begin
               if (open_grp && REG_WDATA >= FREQ_120 &&
                   REG_WDATA <= FREQ_400) begin
                  cfg_next.hs_lim = REG_WDATA;
                  cfg_next.max_lim = REG_WDATA;
               end
            end
            OFS_MIN_LIMIT: begin
               if (REG_WDATA <= FREQ_120) begin
                  cfg_next.min_lim = REG_WDATA;
               end
            end
            OFS_JOG: begin
               if (REG_WDATA <= FREQ_400) begin
                  cfg_next.jog = REG_WDATA;
               end
            end
            OFS_LAUNCH: begin
               if (REG_WDATA <= FREQ_400) begin
                  cfg_next.launch = REG_WDATA;
               end
            end
            OFS_KNEE_PRI: begin
               if (REG_WDATA <= FREQ_400) begin
                  cfg_next.knee_pri = REG_WDATA;
               end
            end
            OFS_KNEE_V: begin
               if (open_grp && (REG_WDATA <= VOLT_MAX ||
                   REG_WDATA == CODE_95PCT || REG_WDATA == CODE_OFF)) begin
                  cfg_next.knee_v = REG_WDATA;
               end
            end
            OFS_KNEE_ALT: begin
               if (open_grp &&
                   (REG_WDATA <= FREQ_400 || REG_WDATA == CODE_OFF)) begin
                  cfg_next.knee_alt = REG_WDATA;
               end
            end
            OFS_PROFILE: begin
               if (REG_WDATA <= PROF_MAX) begin
                  cfg_next.profile = ofv_profile_t'(REG_WDATA[1:0]);
               end
            end
            OFS_VIS_GRP: cfg_next.vis_grp = REG_WDATA;
            OFS_RAMP_SHAPE: cfg_next.ramp_shape = REG_WDATA;
            OFS_RATED_V: begin
               if (REG_WDATA <= VOLT_MAX) begin
                  cfg_next.rated_v = REG_WDATA;
               end
            end
            OFS_RATED_F: begin
               if (REG_WDATA <= FREQ_400) begin
                  cfg_next.rated_f = REG_WDATA;
               end
            end
            OFS_ACCEL_STEP: cfg_next.accel_step = REG_WDATA;
            OFS_CTRL: cfg_next.vec_mode = REG_WDATA[CTRL_VEC_BIT];
            default: ;
         endcase
      end
   end

   // read mux; data appear only in the cycle after the strobe
   always_comb begin
      rdata_next = 16'h0000;
      if (REG_RD) begin
         case (REG_ADDR)
            OFS_MAX_LIMIT: rdata_next = cfg_reg.max_lim;
            OFS_MIN_LIMIT: rdata_next = cfg_reg.min_lim;
            OFS_HS_LIMIT: rdata_next = cfg_reg.hs_lim;
            OFS_JOG: rdata_next = cfg_reg.jog;
            OFS_LAUNCH: rdata_next = cfg_reg.launch;
            OFS_KNEE_PRI: rdata_next = cfg_reg.knee_pri;
            OFS_KNEE_V: rdata_next = cfg_reg.knee_v;
            OFS_KNEE_ALT: rdata_next = cfg_reg.knee_alt;
            OFS_PROFILE: rdata_next = {14'h0000, cfg_reg.profile};
            OFS_VIS_GRP: rdata_next = cfg_reg.vis_grp;
            OFS_RAMP_SHAPE: rdata_next = cfg_reg.ramp_shape;
            OFS_RATED_V: rdata_next = cfg_reg.rated_v;
            OFS_RATED_F: rdata_next = cfg_reg.rated_f;
            OFS_ACCEL_STEP: rdata_next = cfg_reg.accel_step;
            OFS_CTRL: rdata_next = {15'h0000, cfg_reg.vec_mode};
            OFS_FREQ_STAT: rdata_next = freq_reg;
            OFS_VOLT_STAT: rdata_next = volt_reg;
            OFS_KNEE_STAT: rdata_next = knee_reg;
            OFS_FLAG_STAT: rdata_next = {12'h000, flag_reg};
            default: begin
               for (int i = 0; i < NUM_BANDS; i++) begin
                  if (REG_ADDR ==
                      OFS_SKIP_BASE + 8'(i) * OFS_SKIP_STRIDE) begin
                     rdata_next = cfg_reg.skip_a[i];
                  end
                  if (REG_ADDR == OFS_SKIP_BASE + 8'(i) * OFS_SKIP_STRIDE
                      + OFS_SKIP_B) begin
                     rdata_next = cfg_reg.skip_b[i];
                  end
               end
            end
         endcase
      end
   end

   // settings and read data registers
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cfg_reg <= CFG_RESET;
         rdata_reg <= 16'h0000;
      end else begin
         cfg_reg <= cfg_next;
         rdata_reg <= rdata_next;
      end
   end

   // command selection and limits
   assign run = START || JOG;
   always_comb begin
      lower_f = cfg_reg.min_lim;
      if (JOG && cfg_reg.jog <= cfg_reg.min_lim) begin
         lower_f = cfg_reg.jog;
      end
      if (JOG) begin
         raw_f = cfg_reg.jog;
      end else if (FREQ_CMD_VALID) begin
         raw_f = FREQ_CMD;
      end else if (cfg_reg.min_lim >= cfg_reg.launch) begin
         raw_f = cfg_reg.min_lim;
      end else begin
         raw_f = 16'h0000;
      end
      clamped_f = (raw_f > cfg_reg.max_lim) ? cfg_reg.max_lim : raw_f;
      if (clamped_f < lower_f) begin
         clamped_f = lower_f;
      end
   end

   ofv_skip_bands u_skip (
      .BAND_A(cfg_reg.skip_a),
      .BAND_B(cfg_reg.skip_b),
      .FREQ_IN(clamped_f),
      .FREQ_OUT(skipped_f),
      .HIT(skip_hit)
   );

   // stall prevention overrides the floor; stopped target is zero
   always_comb begin
      target_f = 16'h0000;
      if (run) begin
         target_f = skipped_f;
         if (STALL_ACTIVE && STALL_FREQ < skipped_f) begin
            target_f = STALL_FREQ;
         end
      end
   end

   // millisecond tick divider sets the ramp rate
   always_comb begin
      tick = (tick_cnt_reg == TICK_LAST);
      tick_cnt_next = tick ? 32'h00000000 : tick_cnt_reg + 32'h00000001;
   end

   // knee and base voltage selection
   assign alt_on = ALT_SET_SELECT && (cfg_reg.knee_alt != CODE_OFF);
   assign supply95 = 16'((32'(SUPPLY_VOLT) * PCT_95) / PCT_FULL);
   always_comb begin
      if (cfg_reg.vec_mode) begin
         knee_f = cfg_reg.rated_f;
         base_v = cfg_reg.rated_v;
      end else begin
         knee_f = alt_on ? cfg_reg.knee_alt : cfg_reg.knee_pri;
         if (cfg_reg.knee_v == CODE_95PCT) begin
            base_v = supply95;
         end else if (cfg_reg.knee_v == CODE_OFF) begin
            base_v = SUPPLY_VOLT;
         end else if (cfg_reg.knee_v < SUPPLY_VOLT) begin
            base_v = cfg_reg.knee_v;
         end else begin
            base_v = SUPPLY_VOLT;
         end
      end
   end

   // ramp step; halved above the knee for the curved shape, kept nonzero
   always_comb begin
      step = cfg_reg.accel_step;
      if (cfg_reg.ramp_shape == RAMP_S_CODE && freq_reg >= knee_f) begin
         step = {1'b0, cfg_reg.accel_step[DATA_W-1:1]};
      end
      if (step == 16'h0000) begin
         step = 16'h0001;
      end
      freq_next = freq_reg;
      if (tick) begin
         if (target_f > freq_reg) begin
            freq_next = (target_f - freq_reg > step) ? freq_reg + step
                                                     : target_f;
         end else if (target_f < freq_reg) begin
            freq_next = (freq_reg - target_f > step) ? freq_reg - step
                                                     : target_f;
         end
      end
   end

   // voltage pattern and boost from the ramped frequency
   always_comb begin
      if (knee_f == 16'h0000 || freq_reg >= knee_f) begin
         volt_next = base_v;
      end else if (!cfg_reg.vec_mode && cfg_reg.profile == PROF_VAR) begin
         volt_next = 16'((48'(base_v) * 48'(freq_reg) * 48'(freq_reg)) /
                         (48'(knee_f) * 48'(knee_f)));
      end else begin
         volt_next = 16'((32'(base_v) * 32'(freq_reg)) / 32'(knee_f));
      end
      boost_next = TORQUE_BOOST;
      if (!cfg_reg.vec_mode) begin
         unique case (cfg_reg.profile)
            PROF_LIFT_REV: if (REVERSE) boost_next = 16'h0000;
            PROF_LIFT_FWD: if (!REVERSE) boost_next = 16'h0000;
            PROF_CONST, PROF_VAR: ;
         endcase
      end
      knee_next = knee_f;
      flag_next = '0;
      flag_next[FLAG_UPPER_BIT] = run && (raw_f > cfg_reg.max_lim);
      flag_next[FLAG_LOWER_BIT] = run && (raw_f < lower_f);
      flag_next[FLAG_SKIP_BIT] = run && skip_hit;
      flag_next[FLAG_ALT_BIT] = alt_on && !cfg_reg.vec_mode;
   end

   // datapath registers
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         tick_cnt_reg <= 32'h00000000;
         freq_reg <= 16'h0000;
         volt_reg <= 16'h0000;
         boost_reg <= 16'h0000;
         knee_reg <= FREQ_60;
         flag_reg <= 4'h0;
      end else begin
         tick_cnt_reg <= tick_cnt_next;
         freq_reg <= freq_next;
         volt_reg <= volt_next;
         boost_reg <= boost_next;
         knee_reg <= knee_next;
         flag_reg <= flag_next;
      end
   end

   assign REG_RDATA = rdata_reg;
   assign FREQ_OUT = freq_reg;
   assign VOLT_OUT = volt_reg;
   assign BOOST_OUT = boost_reg;
   assign KNEE_FREQ_OUT = knee_reg;
   assign S_CURVE_ACTIVE = (cfg_reg.ramp_shape == RAMP_S_CODE);

   // checks on the limits, mirroring, voltage pattern, boost and ramp step
   chk_upper_clamp_cmd: assert property (@(posedge CLK) disable iff (!RST_N)
      (START && !JOG && FREQ_CMD_VALID && FREQ_CMD > cfg_reg.max_lim &&
       !STALL_ACTIVE && !skip_hit) |-> target_f == cfg_reg.max_lim)
      else $error("command above maximum not clamped");
   chk_max_mirror: assert property (@(posedge CLK) disable iff (!RST_N)
      (REG_WR && REG_ADDR == OFS_MAX_LIMIT && REG_WDATA <= FREQ_120) |=>
      (cfg_reg.hs_lim == $past(REG_WDATA) &&
       cfg_reg.max_lim == $past(REG_WDATA)))
      else $error("maximum write not mirrored");
   chk_hs_mirror: assert property (@(posedge CLK) disable iff (!RST_N)
      (REG_WR && REG_ADDR == OFS_HS_LIMIT && open_grp &&
       REG_WDATA >= FREQ_120 && REG_WDATA <= FREQ_400) |=>
      cfg_reg.max_lim == $past(REG_WDATA))
      else $error("high-speed write not mirrored");
   chk_lower_clamp: assert property (@(posedge CLK) disable iff (!RST_N)
      (START && !JOG && !STALL_ACTIVE && !skip_hit) |->
      target_f >= cfg_reg.min_lim)
      else $error("target below minimum");
   chk_jog_precedence: assert property (@(posedge CLK) disable iff (!RST_N)
      (JOG && cfg_reg.jog <= cfg_reg.min_lim && !STALL_ACTIVE && !skip_hit)
      |-> target_f == cfg_reg.jog)
      else $error("jog speed lost to minimum");
   chk_stall_floor: assert property (@(posedge CLK) disable iff (!RST_N)
      (run && STALL_ACTIVE && STALL_FREQ < skipped_f) |->
      target_f == STALL_FREQ)
      else $error("stall frequency not applied");
   chk_alt_knee: assert property (@(posedge CLK) disable iff (!RST_N)
      (ALT_SET_SELECT && !cfg_reg.vec_mode && cfg_reg.knee_alt != CODE_OFF)
      |=> KNEE_FREQ_OUT == $past(cfg_reg.knee_alt))
      else $error("alternate knee not used");
   chk_volt_above_knee: assert property (@(posedge CLK) disable iff (!RST_N)
      (knee_f != 16'h0000 && freq_reg >= knee_f) |=>
      VOLT_OUT == $past(base_v))
      else $error("voltage above knee not held");
   chk_volt_cap: assert property (@(posedge CLK) disable iff (!RST_N)
      (!cfg_reg.vec_mode && cfg_reg.knee_v < SUPPLY_VOLT) |=>
      VOLT_OUT <= $past(cfg_reg.knee_v))
      else $error("voltage exceeds knee voltage");
   chk_boost_reverse: assert property (@(posedge CLK) disable iff (!RST_N)
      (!cfg_reg.vec_mode && cfg_reg.profile == PROF_LIFT_REV && REVERSE) |=>
      BOOST_OUT == 16'h0000)
      else $error("boost not zero in reverse");
   chk_ramp_step: assert property (@(posedge CLK) disable iff (!RST_N)
      (tick && target_f > freq_reg) |=> (freq_reg > $past(freq_reg) &&
       freq_reg <= $past(target_f)))
      else $error("ramp did not advance");

   cov_jog_run: cover property (@(posedge CLK) disable iff (!RST_N)
      JOG && tick && freq_reg != target_f);
   cov_skip_hit: cover property (@(posedge CLK) disable iff (!RST_N)
      run && skip_hit);
   cov_square_law: cover property (@(posedge CLK) disable iff (!RST_N)
      cfg_reg.profile == PROF_VAR && freq_reg < knee_f && freq_reg != 0);
   cov_alt_knee: cover property (@(posedge CLK) disable iff (!RST_N)
      alt_on ##1 !alt_on);

endmodule : ofv_limit_vf
`default_nettype wire

// ---- include/ofv_pkg.sv ----
/*
 ofv_pkg: settings layout, register offsets, setting codes, reset values
 and timing constants for the output frequency limit and V/F block.
 Assumes frequencies in 0.1 Hz steps and voltages in 1 V steps, so the
 disable code 9999 and the 95 % code 8888 lie outside every legal range.
*/
package ofv_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned NUM_BANDS = 3;

   typedef logic [DATA_W-1:0] ofv_word_t;

   // load profile encodings, in setting order 0..3
   typedef enum logic [1:0] {
      PROF_CONST,
      PROF_VAR,
      PROF_LIFT_REV,
      PROF_LIFT_FWD
   } ofv_profile_t;

   // settings written by software
   typedef struct packed {
      ofv_word_t max_lim;
      ofv_word_t min_lim;
      ofv_word_t hs_lim;
      ofv_word_t jog;
      ofv_word_t launch;
      logic [NUM_BANDS-1:0][DATA_W-1:0] skip_a;
      logic [NUM_BANDS-1:0][DATA_W-1:0] skip_b;
      ofv_word_t knee_pri;
      ofv_word_t knee_v;
      ofv_word_t knee_alt;
      ofv_profile_t profile;
      ofv_word_t vis_grp;
      ofv_word_t ramp_shape;
      ofv_word_t rated_v;
      ofv_word_t rated_f;
      ofv_word_t accel_step;
      logic vec_mode;
   } ofv_cfg_t;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_MAX_LIMIT = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_MIN_LIMIT = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_HS_LIMIT = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_JOG = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_LAUNCH = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_SKIP_BASE = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_SKIP_STRIDE = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_SKIP_B = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_KNEE_PRI = 8'h2C;
   localparam logic [ADDR_W-1:0] OFS_KNEE_V = 8'h30;
   localparam logic [ADDR_W-1:0] OFS_KNEE_ALT = 8'h34;
   localparam logic [ADDR_W-1:0] OFS_PROFILE = 8'h38;
   localparam logic [ADDR_W-1:0] OFS_VIS_GRP = 8'h3C;
   localparam logic [ADDR_W-1:0] OFS_RAMP_SHAPE = 8'h40;
   localparam logic [ADDR_W-1:0] OFS_RATED_V = 8'h44;
   localparam logic [ADDR_W-1:0] OFS_RATED_F = 8'h48;
   localparam logic [ADDR_W-1:0] OFS_ACCEL_STEP = 8'h4C;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h50;
   localparam logic [ADDR_W-1:0] OFS_FREQ_STAT = 8'h54;
   localparam logic [ADDR_W-1:0] OFS_VOLT_STAT = 8'h58;
   localparam logic [ADDR_W-1:0] OFS_KNEE_STAT = 8'h5C;
   localparam logic [ADDR_W-1:0] OFS_FLAG_STAT = 8'h60;

   // field positions
   localparam int unsigned CTRL_VEC_BIT = 0;
   localparam int unsigned FLAG_UPPER_BIT = 0;
   localparam int unsigned FLAG_LOWER_BIT = 1;
   localparam int unsigned FLAG_SKIP_BIT = 2;
   localparam int unsigned FLAG_ALT_BIT = 3;

   // setting codes and limits
   localparam ofv_word_t CODE_OFF = 16'h270F;
   localparam ofv_word_t CODE_95PCT = 16'h22B8;
   localparam ofv_word_t FREQ_120 = 16'h04B0;
   localparam ofv_word_t FREQ_400 = 16'h0FA0;
   localparam ofv_word_t FREQ_60 = 16'h0258;
   localparam ofv_word_t VOLT_MAX = 16'h03E8;
   localparam ofv_word_t RAMP_S_CODE = 16'h0001;
   localparam ofv_word_t PROF_MAX = 16'h0003;
   localparam logic [31:0] PCT_95 = 32'h0000005F;
   localparam logic [31:0] PCT_FULL = 32'h00000064;

   // reset values
   localparam ofv_word_t RST_ACCEL_STEP = 16'h0001;
   localparam ofv_cfg_t CFG_RESET = '{
      max_lim: FREQ_120, min_lim: 16'h0000, hs_lim: FREQ_120,
      jog: 16'h0032, launch: 16'h0005,
      skip_a: {NUM_BANDS{CODE_OFF}}, skip_b: {NUM_BANDS{CODE_OFF}},
      knee_pri: FREQ_60, knee_v: CODE_OFF, knee_alt: CODE_OFF,
      profile: PROF_CONST, vis_grp: 16'h0000, ramp_shape: 16'h0000,
      rated_v: 16'h00C8, rated_f: FREQ_60, accel_step: RST_ACCEL_STEP,
      vec_mode: 1'b0
   };

   // ramp tick timing
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned RAMP_TICK_US = 1000;
   localparam int unsigned RAMP_TICK_CYC = (CLK_HZ / 1000000) * RAMP_TICK_US;

endpackage : ofv_pkg

// ---- logic/ofv_skip_bands.sv ----
/*
 ofv_skip_bands: pushes a frequency out of up to three resonance bands.
 Assumes a combinational path inside the caller's single clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module ofv_skip_bands
   import ofv_pkg::*;
(
   // band settings
   input wire logic [NUM_BANDS-1:0][DATA_W-1:0] BAND_A,
   input wire logic [NUM_BANDS-1:0][DATA_W-1:0] BAND_B,
   // frequency in and out
   input wire ofv_word_t FREQ_IN,
   output ofv_word_t FREQ_OUT,
   output logic HIT
);

   logic [NUM_BANDS-1:0] hit_v;
   logic [NUM_BANDS-1:0][DATA_W-1:0] low_edge;

   // per band: order the edges, test membership; 9999 in either disables
   genvar gi;
   generate
      for (gi = 0; gi < NUM_BANDS; gi++) begin : g_band
         logic [DATA_W-1:0] lo;
         logic [DATA_W-1:0] hi;
         logic on;
         assign lo = (BAND_A[gi] < BAND_B[gi]) ? BAND_A[gi] : BAND_B[gi];
         assign hi = (BAND_A[gi] < BAND_B[gi]) ? BAND_B[gi] : BAND_A[gi];
         assign on = (BAND_A[gi] != CODE_OFF) && (BAND_B[gi] != CODE_OFF);
         assign hit_v[gi] = on && (FREQ_IN > lo) && (FREQ_IN <= hi);
         assign low_edge[gi] = lo;
      end
   endgenerate

   // hold at the lower edge; band 0 wins over bands 1 and 2 where bands overlap, whatever their frequencies
   always_comb begin
      FREQ_OUT = FREQ_IN;
      for (int i = NUM_BANDS - 1; i >= 0; i--) begin
         if (hit_v[i]) begin
            FREQ_OUT = low_edge[i];
         end
      end
   end

   assign HIT = |hit_v;

endmodule : ofv_skip_bands
`default_nettype wire

// ---- dv/tb_ofv_limit_vf.sv ----
/* tb_ofv_limit_vf: register and drive-path tests of ofv_limit_vf.
 Assumes a ramp tick of 4 cycles and one clock for all inputs. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) chk_val(a, e);
module tb_ofv_limit_vf import ofv_pkg::*;;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rdn = 1'b0, cv = 1'b0;
   logic st = 1'b0, jg = 1'b0, alt = 1'b0, rev = 1'b0, sa = 1'b0, sc;
   logic [ADDR_W-1:0] ad = 8'h00;
   ofv_word_t wd = 16'h0000, cmd = 16'h0000, sf = 16'h0064;
   ofv_word_t sv = 16'h00C8, tb = 16'h0020, rd, fo, vo, bo, ko;
   int n_errors = 0, cmp_count = 0, cyc = 0;
   // 25 MHz clock
   always #20 clk = ~clk;
   ofv_limit_vf #(.TICK_CYC(4)) i_dut (.CLK(clk), .RST_N(rst_n),
      .REG_ADDR(ad), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rdn),
      .REG_RDATA(rd), .FREQ_CMD(cmd), .FREQ_CMD_VALID(cv), .START(st),
      .JOG(jg), .ALT_SET_SELECT(alt), .REVERSE(rev), .STALL_ACTIVE(sa),
      .STALL_FREQ(sf), .SUPPLY_VOLT(sv), .TORQUE_BOOST(tb),
      .FREQ_OUT(fo), .VOLT_OUT(vo), .BOOST_OUT(bo), .KNEE_FREQ_OUT(ko),
      .S_CURVE_ACTIVE(sc));
   task automatic chk_val(input ofv_word_t a, input ofv_word_t e);
      cmp_count++;
      if (a !== e) begin
         n_errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, a, e);
      end
   endtask : chk_val
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish
   // one-cycle write strobe; a gap cycle keeps strobes from merging
   task automatic wreg(input logic [ADDR_W-1:0] a, input ofv_word_t d);
      @(posedge clk);
      ad <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   // read data stand only in the cycle after the strobe
   task automatic rreg(input logic [ADDR_W-1:0] a, input ofv_word_t e);
      @(posedge clk);
      ad <= a;
      rdn <= 1'b1;
      @(posedge clk);
      rdn <= 1'b0;
      @(negedge clk);
      `CHK(rd, e)
   endtask : rreg
   // several ramp ticks, voltage follows one cycle later
   task automatic settle;
      repeat (24) @(posedge clk);
      @(negedge clk);
   endtask : settle
   task automatic frq(input ofv_word_t c, input logic v, input ofv_word_t e);
      @(posedge clk);
      cmd <= c;
      cv <= v;
      settle();
      `CHK(fo, e)
   endtask : frq
   // hang guard, well above the length of the sequence
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rreg(OFS_MAX_LIMIT, FREQ_120);
      rreg(OFS_HS_LIMIT, FREQ_120);
      rreg(OFS_SKIP_BASE, CODE_OFF);
      rreg(OFS_KNEE_PRI, FREQ_60);
      rreg(OFS_KNEE_V, CODE_OFF);
      rreg(OFS_PROFILE, 16'h0000);
      rreg(8'hFC, 16'h0000);
      wreg(OFS_HS_LIMIT, 16'h07D0);
      rreg(OFS_MAX_LIMIT, 16'h07D0);
      wreg(OFS_MAX_LIMIT, 16'h03E8);
      rreg(OFS_HS_LIMIT, 16'h03E8);
      wreg(OFS_ACCEL_STEP, FREQ_400);
      st <= 1'b1;
      frq(16'h05DC, 1'b1, 16'h03E8);
      wreg(OFS_MIN_LIMIT, 16'h012C);
      frq(16'h0064, 1'b1, 16'h012C);
      frq(16'h0000, 1'b0, 16'h012C);
      @(posedge clk);
      jg <= 1'b1;
      frq(16'h0000, 1'b0, 16'h0032);
      @(posedge clk);
      jg <= 1'b0;
      sa <= 1'b1;
      frq(16'h01F4, 1'b1, 16'h0064);
      @(posedge clk);
      sa <= 1'b0;
      wreg(OFS_SKIP_BASE, 16'h0190);
      wreg(OFS_SKIP_BASE + OFS_SKIP_B, 16'h01F4);
      frq(16'h01C2, 1'b1, 16'h0190);
      rreg(OFS_FREQ_STAT, 16'h0190);
      rreg(OFS_FLAG_STAT, 16'h0004);
      frq(16'h012C, 1'b1, 16'h012C);
      `CHK(vo, 16'h0064)
      wreg(OFS_PROFILE, 16'h0001);
      settle();
      `CHK(vo, 16'h0032)
      frq(16'h03E8, 1'b1, 16'h03E8);
      `CHK(vo, 16'h00C8)
      wreg(OFS_KNEE_V, 16'h0064);
      settle();
      `CHK(vo, 16'h0064)
      wreg(OFS_KNEE_V, CODE_95PCT);
      settle();
      `CHK(vo, 16'h00BE)
      wreg(OFS_PROFILE, 16'h0002);
      rev <= 1'b1;
      settle();
      `CHK(bo, 16'h0000)
      wreg(OFS_PROFILE, 16'h0003);
      rev <= 1'b0;
      settle();
      `CHK(bo, 16'h0000)
      wreg(OFS_KNEE_ALT, 16'h012C);
      alt <= 1'b1;
      settle();
      `CHK(ko, 16'h012C)
      wreg(OFS_RAMP_SHAPE, RAMP_S_CODE);
      settle();
      `CHK({15'h0000, sc}, 16'h0001)
      wreg(OFS_CTRL, 16'h0001);
      settle();
      `CHK(ko, 16'h0258)
      `CHK(vo, 16'h00C8)
      `CHK(bo, 16'h0020)
      wreg(OFS_VIS_GRP, 16'h0001);
      wreg(OFS_HS_LIMIT, 16'h0BB8);
      rreg(OFS_MAX_LIMIT, 16'h03E8);
      wreg(OFS_VIS_GRP, 16'h0000);
      tally_and_finish();
   end
endmodule : tb_ofv_limit_vf
`default_nettype wire
